// [hw/gpio_pkg.sv]
// Shared constants and carriers for the two general-purpose ports
package gpio_pkg;

  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int DEC_W = 8;
  localparam int IO_BITS = 4;
  localparam int IN_BITS = 8;
  localparam int CH_W = 4;

  localparam logic [DEC_W-1:0] BIDIR_DATA_OFS = 8'h00;
  localparam logic [DEC_W-1:0] BIDIR_DIR_OFS = 8'h04;
  localparam logic [DEC_W-1:0] INPORT_OFS = 8'h08;
  localparam logic [DEC_W-1:0] FUNC_SEL_OFS = 8'h0C;

  localparam logic [IO_BITS-1:0] LATCH_RST = 4'h0;
  localparam logic [IO_BITS-1:0] DIR_RST = 4'h0;
  localparam logic [IO_BITS-1:0] FUNC_SEL_RST = 4'hF;
  localparam logic [REG_W-1:0] DIR_READ_VAL = 8'hFF;

  localparam logic [CH_W-1:0] ANA_FIRST_CODE = 4'h4;
  localparam logic [CH_W-1:0] ANA_LAST_CODE = 4'hB;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic valid;
    logic write;
    logic [DEC_W-1:0] ofs;
  } bus_req_s;

  typedef struct packed {
    logic [IO_BITS-1:0] out;
    logic [IO_BITS-1:0] oe;
  } pin_drive_s;

endpackage

// [hw/gpio_ports.sv]
// AHB-Lite register block for a four-bit I/O port and an eight-bit input port
`timescale 1ns/100ps
module gpio_ports
  import gpio_pkg::*;
#(
  parameter int IO_WIDTH = IO_BITS,
  parameter int IN_WIDTH = IN_BITS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [DATA_W-1:0] hrdata,
  input wire logic [IO_WIDTH-1:0] bidir_in,
  output logic [IO_WIDTH-1:0] bidir_out,
  output logic [IO_WIDTH-1:0] bidir_oe,
  input wire logic [IO_WIDTH-1:0] alt_out,
  input wire logic [IO_WIDTH-1:0] alt_oe,
  input wire logic [IN_WIDTH-1:0] inport_in,
  input wire logic [CH_W-1:0] converter_channel_field,
  input wire logic [IN_WIDTH-1:0] aux_analog_select
);

  generate
    // Reset constants and the upper ones field are sized for four port bits
    if (IO_WIDTH < 1 || IO_WIDTH > IO_BITS) begin : g_io_chk
      $error("IO_WIDTH must lie in 1..4");
    end
    if (IN_WIDTH < 1 || IN_WIDTH > REG_W) begin : g_in_chk
      $error("IN_WIDTH must lie in 1..8");
    end
  endgenerate

  // Bus request capture
  bus_req_s req_r;
  bus_req_s req_nxt;
  wire addr_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans[1]);

  assign req_nxt.valid = addr_take;
  assign req_nxt.write = hwrite;
  assign req_nxt.ofs = haddr[DEC_W-1:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_r <= '0;
    end else begin
      req_r <= req_nxt;
    end
  end

  // Write decode in the data phase
  wire wr_phase = req_r.valid && req_r.write;
  wire wr_data = wr_phase && (req_r.ofs == BIDIR_DATA_OFS);
  wire wr_dir = wr_phase && (req_r.ofs == BIDIR_DIR_OFS);
  wire wr_func = wr_phase && (req_r.ofs == FUNC_SEL_OFS);

  // Control registers
  // Function select: one keeps a pin on the port, zero hands it to alt_out and alt_oe
  logic [IO_WIDTH-1:0] latch_r;
  logic [IO_WIDTH-1:0] dir_r;
  logic [IO_WIDTH-1:0] func_sel_r;
  logic [IO_WIDTH-1:0] latch_nxt;
  logic [IO_WIDTH-1:0] dir_nxt;
  logic [IO_WIDTH-1:0] func_sel_nxt;

  // Upper byte bits are dropped on write
  assign latch_nxt = wr_data ? hwdata[IO_WIDTH-1:0] : latch_r;
  assign dir_nxt = wr_dir ? hwdata[IO_WIDTH-1:0] : dir_r;
  assign func_sel_nxt = wr_func ? hwdata[IO_WIDTH-1:0] : func_sel_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_r <= LATCH_RST[IO_WIDTH-1:0];
      dir_r <= DIR_RST[IO_WIDTH-1:0];
      func_sel_r <= FUNC_SEL_RST[IO_WIDTH-1:0];
    end else begin
      latch_r <= latch_nxt;
      dir_r <= dir_nxt;
      func_sel_r <= func_sel_nxt;
    end
  end

  // Pin sampling
  // Pins are asynchronous, so reads trail a new level by two edges
  logic [IO_WIDTH-1:0] bidir_sync;
  logic [IN_WIDTH-1:0] inport_sync;

  pin_sync #(
    .WIDTH(IO_WIDTH)
  ) u_bidir_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(bidir_in),
    .q(bidir_sync)
  );

  pin_sync #(
    .WIDTH(IN_WIDTH)
  ) u_inport_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(inport_in),
    .q(inport_sync)
  );

  // Per-bit read views
  logic [IO_WIDTH-1:0] io_view;
  logic [IN_WIDTH-1:0] analog_hit;
  logic [IN_WIDTH-1:0] in_view;

  genvar gi;
  generate
    for (gi = 0; gi < IO_WIDTH; gi++) begin : g_io
      // Uses next values so a read straight after a write sees it
      assign io_view[gi] = dir_nxt[gi] ? latch_nxt[gi] : bidir_sync[gi];
    end
    for (gi = 0; gi < IN_WIDTH; gi++) begin : g_in
      localparam logic [CH_W-1:0] CODE = CH_W'(ANA_FIRST_CODE + gi);
      assign analog_hit[gi] = (converter_channel_field == CODE)
        || aux_analog_select[gi];
      assign in_view[gi] = analog_hit[gi] ? 1'b0 : inport_sync[gi];
    end
  endgenerate

  // Read mux, decided in the address phase
  wire [DEC_W-1:0] rd_ofs = haddr[DEC_W-1:0];
  wire rd_take = addr_take && !hwrite;
  wire [REG_W-1:0] data_byte = {{(REG_W-IO_WIDTH){1'b1}}, io_view};
  wire [REG_W-1:0] dir_byte = DIR_READ_VAL;
  wire [REG_W-1:0] inport_byte = {{(REG_W-IN_WIDTH){1'b0}}, in_view};
  wire [REG_W-1:0] func_byte = {{(REG_W-IO_WIDTH){1'b0}}, func_sel_nxt};
  wire [REG_W-1:0] rd_byte =
    (rd_ofs == BIDIR_DATA_OFS) ? data_byte :
    (rd_ofs == BIDIR_DIR_OFS) ? dir_byte :
    (rd_ofs == INPORT_OFS) ? inport_byte :
    (rd_ofs == FUNC_SEL_OFS) ? func_byte : '0;
  wire [DATA_W-1:0] rd_word = {{(DATA_W-REG_W){1'b0}}, rd_byte};

  logic [DATA_W-1:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;

  // Zero wait states: no hazard needs stalling thanks to the bypass
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
      hreadyout_r <= 1'b1;
      hresp_r <= HRESP_OKAY;
    end else begin
      hrdata_r <= rd_take ? rd_word : '0;
      hreadyout_r <= 1'b1;
      hresp_r <= HRESP_OKAY;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;

  // Pin drivers; the input-only port has none at all
  // Loading from next values moves the pins at the edge that stores the register
  pin_drive_s drive_r;
  pin_drive_s drive_nxt;

  assign drive_nxt.oe = (func_sel_nxt & dir_nxt)
    | (~func_sel_nxt & alt_oe);
  assign drive_nxt.out = (func_sel_nxt & latch_nxt)
    | (~func_sel_nxt & alt_out);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_r <= '0;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  assign bidir_out = drive_r.out;
  assign bidir_oe = drive_r.oe;

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Helpers that remember what the address phase asked for
  logic rd_data_q;
  logic rd_dir_q;
  logic rd_in_q;
  logic [IO_WIDTH-1:0] exp_dir_q;
  logic [IO_WIDTH-1:0] exp_latch_q;
  logic [IO_WIDTH-1:0] exp_pin_q;
  logic [IN_WIDTH-1:0] exp_in_q;
  logic [CH_W-1:0] exp_ch_q;
  logic [IN_WIDTH-1:0] exp_aux_q;
  logic rd_func_q;
  logic [IO_WIDTH-1:0] exp_func_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data_q <= 1'b0;
      rd_dir_q <= 1'b0;
      rd_in_q <= 1'b0;
      exp_dir_q <= '0;
      exp_latch_q <= '0;
      exp_pin_q <= '0;
      exp_in_q <= '0;
      exp_ch_q <= '0;
      exp_aux_q <= '0;
      rd_func_q <= 1'b0;
      exp_func_q <= '0;
    end else begin
      rd_data_q <= rd_take && rd_ofs == BIDIR_DATA_OFS;
      rd_dir_q <= rd_take && rd_ofs == BIDIR_DIR_OFS;
      rd_in_q <= rd_take && rd_ofs == INPORT_OFS;
      exp_dir_q <= dir_nxt;
      exp_latch_q <= latch_nxt;
      exp_pin_q <= bidir_sync;
      exp_in_q <= inport_sync;
      exp_ch_q <= converter_channel_field;
      exp_aux_q <= aux_analog_select;
      rd_func_q <= rd_take && rd_ofs == FUNC_SEL_OFS;
      exp_func_q <= func_sel_nxt;
    end
  end

  wire [CH_W-1:0] last_ch = CH_W'(ANA_FIRST_CODE + CH_W'(IN_WIDTH - 1));
  // Write data low bits, kept for the store checks
  wire [IO_WIDTH-1:0] wr_low = hwdata[IO_WIDTH-1:0];

  sequence data_read_s;
    rd_take && rd_ofs == BIDIR_DATA_OFS;
  endsequence

  sequence dir_write_s;
    wr_dir;
  endsequence

  sequence data_write_s;
    wr_data;
  endsequence

  sequence inport_write_s;
    wr_phase && req_r.ofs == INPORT_OFS;
  endsequence

  upper_ones_a: assert property (
    data_read_s |=> hrdata[REG_W-1:IO_WIDTH] == '1 && hrdata[DATA_W-1:REG_W] == '0)
    else $error("data register upper bits not one");

  latch_read_a: assert property (
    rd_data_q |-> (hrdata[IO_WIDTH-1:0] & exp_dir_q) == (exp_latch_q & exp_dir_q))
    else $error("output bit did not read latch");

  pin_read_a: assert property (
    rd_data_q |-> (hrdata[IO_WIDTH-1:0] & ~exp_dir_q) == (exp_pin_q & ~exp_dir_q))
    else $error("input bit did not read pin");

  dir_drive_a: assert property (
    dir_write_s ##1 (func_sel_r == '1 && $stable(func_sel_r))
      |-> bidir_oe == dir_r)
    else $error("driver enable does not follow direction");

  dir_readback_a: assert property (
    rd_dir_q |-> hrdata == {{(DATA_W-REG_W){1'b0}}, DIR_READ_VAL})
    else $error("direction register did not read all ones");

  alt_function_a: assert property (
    ##1 (func_sel_r == '0 && $past(func_sel_r) == '0)
      |-> bidir_oe == $past(alt_oe) && bidir_out == $past(alt_out))
    else $error("released pin still follows port registers");

  reset_input_a: assert property (
    $rose(hresetn) |-> dir_r == '0 && latch_r == '0 && bidir_oe == '0)
    else $error("port did not start as input");

  inport_live_a: assert property (
    rd_in_q && exp_aux_q == '0 && (exp_ch_q < ANA_FIRST_CODE || exp_ch_q > last_ch)
      |-> hrdata == {{(DATA_W-IN_WIDTH){1'b0}}, exp_in_q})
    else $error("input port did not return pin levels");

  analog_zero_a: assert property (
    rd_in_q |-> (hrdata[IN_WIDTH-1:0] & exp_aux_q) == '0)
    else $error("aux analog pin read nonzero");

  channel_map_a: assert property (
    rd_in_q && exp_ch_q >= ANA_FIRST_CODE && exp_ch_q <= last_ch
      |-> hrdata[exp_ch_q - ANA_FIRST_CODE] == 1'b0)
    else $error("selected analog channel read nonzero");

  latch_drive_a: assert property (
    ##1 ((func_sel_r & dir_r) != '0 && $stable(latch_r) && $stable(func_sel_r))
      |-> ((bidir_out ^ latch_r) & func_sel_r & dir_r) == '0)
    else $error("output pin not driven with latch");

  latch_store_a: assert property (
    data_write_s |=> latch_r == $past(wr_low))
    else $error("data write did not reach the latch");

  dir_store_a: assert property (
    dir_write_s |=> dir_r == $past(wr_low))
    else $error("direction write did not reach the register");

  input_release_a: assert property (
    ##1 ($stable(dir_r) && $stable(func_sel_r))
      |-> (bidir_oe & func_sel_r & ~dir_r) == '0)
    else $error("input pin still driven");

  inport_readonly_a: assert property (
    inport_write_s |=> $stable(latch_r) && $stable(dir_r) && $stable(func_sel_r))
    else $error("write to input port changed a register");

  func_readback_a: assert property (
    rd_func_q |-> hrdata == {{(DATA_W-IO_WIDTH){1'b0}}, exp_func_q})
    else $error("function select did not read back");

  idle_data_zero_a: assert property (
    !rd_take |=> hrdata == '0)
    else $error("read data not cleared outside a read");

  // Registers change only through their own write
  dir_hold_a: assert property (
    !wr_dir |=> $stable(dir_r))
    else $error("direction changed without a write");

  latch_hold_a: assert property (
    !wr_data |=> $stable(latch_r))
    else $error("latch changed without a write");

  bus_okay_a: assert property (
    hreadyout && hresp == HRESP_OKAY)
    else $error("slave stalled or answered with error");

endmodule

// [hw/pin_sync.sv]
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("pin_sync width must be positive");
    end
  endgenerate

  // First stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule

// [testbench/pin_partner.sv]
// Model of the external pins of the four-bit I/O port
`timescale 1ns/100ps
module pin_partner
  import gpio_pkg::*;
(
  input wire logic [IO_BITS-1:0] oe,
  input wire logic [IO_BITS-1:0] out,
  input wire logic [IO_BITS-1:0] ext,
  input wire logic fight,
  output logic [IO_BITS-1:0] level
);
  // Fight forces driven pins to the opposite level, so latch reads can be told apart
  assign level = (oe & (fight ? ~out : out)) | (~oe & ext);
endmodule

// [testbench/tb_gpio_ports.sv]
// Self-checking testbench for the two general-purpose ports
`timescale 1ns/100ps
module tb_gpio_ports;
  import gpio_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [DATA_W-1:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [DATA_W-1:0] hrdata;
  logic [3:0] bidir_in;
  logic [3:0] bidir_out;
  logic [3:0] bidir_oe;
  logic [3:0] alt_out = 4'h0;
  logic [3:0] alt_oe = 4'h0;
  logic [3:0] ext = 4'h0;
  logic fight = 1'b0;
  logic [7:0] inport_in = 8'h0;
  logic [7:0] aux = 8'h0;
  logic [3:0] chan = 4'h0;
  logic [31:0] rd;
  int fails = 0;
  int compares = 0;

  always #5 hclk = ~hclk;

  gpio_ports gpio_ports_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .bidir_in(bidir_in),
    .bidir_out(bidir_out),
    .bidir_oe(bidir_oe),
    .alt_out(alt_out),
    .alt_oe(alt_oe),
    .inport_in(inport_in),
    .converter_channel_field(chan),
    .aux_analog_select(aux)
  );

  pin_partner pin_partner_inst (
    .oe(bidir_oe),
    .out(bidir_out),
    .ext(ext),
    .fight(fight),
    .level(bidir_in)
  );

  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Values are sampled in the active region, before the edge's own updates land
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        end_of_test;
      end
      @(posedge hclk);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task t_reset;
    ext <= 4'h5;
    tick(3);
    chk({28'h0, bidir_oe}, 32'h0);
    chk({28'h0, bidir_out}, 32'h0);
    rchk(BIDIR_DATA_OFS, 32'hF5);
    rchk(BIDIR_DIR_OFS, 32'hFF);
    rchk(8'h10, 32'h0);
  endtask

  task t_dir;
    bus(1'b1, BIDIR_DATA_OFS, 32'h35);
    bus(1'b1, BIDIR_DIR_OFS, 32'hF3);
    fight <= 1'b1;
    ext <= 4'hA;
    tick(3);
    chk({28'h0, bidir_oe}, 32'h3);
    chk({28'h0, bidir_out}, 32'h5);
    rchk(BIDIR_DATA_OFS, 32'hF9);
    rchk(BIDIR_DIR_OFS, 32'hFF);
    bus(1'b1, BIDIR_DIR_OFS, 32'hFC);
    tick(3);
    chk({28'h0, bidir_oe}, 32'hC);
    rchk(BIDIR_DATA_OFS, 32'hF6);
    fight <= 1'b0;
  endtask

  task t_func;
    alt_out <= 4'h9;
    alt_oe <= 4'h6;
    bus(1'b1, FUNC_SEL_OFS, 32'h0);
    tick(2);
    chk({28'h0, bidir_oe}, 32'h6);
    chk({28'h0, bidir_out}, 32'h9);
    bus(1'b1, FUNC_SEL_OFS, 32'hF);
    tick(2);
    chk({28'h0, bidir_oe}, 32'hC);
    rchk(FUNC_SEL_OFS, 32'hF);
  endtask

  task t_inport;
    logic [7:0] e;
    inport_in <= 8'hFF;
    for (int c = 0; c < 16; c++) begin
      chan <= c[3:0];
      tick(3);
      e = 8'hFF;
      if (c >= 4 && c <= 11) begin
        e[c-4] = 1'b0;
      end
      rchk(INPORT_OFS, {24'h0, e});
    end
    chan <= 4'h0;
    aux <= 8'h81;
    inport_in <= 8'hA5;
    bus(1'b1, INPORT_OFS, 32'h0);
    tick(3);
    rchk(INPORT_OFS, 32'h24);
  endtask

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_dir;
    t_func;
    t_inport;
    end_of_test;
  end
endmodule
